/* verilog/icx_ctrl.sv */
// Interrupt controller with program-counter stack and APB registers.
// Assumes peripherals give one-cycle event pulses and the core issues
// at most one of call, return or interrupt return per cycle.
module icx_ctrl
  import icx_pkg::*;
#(
  parameter int STACK_DEPTH = ICX_STACK_DEPTH,
  parameter bit HAS_SERIAL_MODULE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire icx_src_t src_event,
  input wire icx_core_in_t core_in,
  output icx_core_out_t core_out,
  output logic wake_pulse,
  output logic irq
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

  typedef struct packed {
    icx_apb_t apb;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] shared;
    logic gie;
    logic mf_flag;
    logic mf_en;
    logic [1:0] ded_flag;
    logic [1:0] ded_en;
    logic mf_req_prev;
    logic [2:0] stat;
    logic [2:0] mask;
    logic irq;
    logic wake;
    icx_core_out_t core;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][ICX_PC_W-1:0] stack;
  } icx_state_t;

  icx_state_t s_reg;
  icx_state_t s_next;
  logic take;
  icx_sel_t sel;
  logic wr_acc;
  logic rd_acc;

  // Implemented bits of the shared register
  function automatic logic [7:0] icx_impl_mask();
    logic [7:0] m;
    m = 8'hFF;
    if (!HAS_SERIAL_MODULE) begin
      m[ICX_SH_SM_FLAG] = 1'b0;
      m[ICX_SH_SM_EN] = 1'b0;
    end
    return m;
  endfunction : icx_impl_mask

  // Control register image
  function automatic logic [7:0] icx_ctrl_image(icx_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[ICX_CT_GIE] = s.gie;
    v[ICX_CT_MF_FLAG] = s.mf_flag;
    v[ICX_CT_DED_FLAG_LSB +: 2] = s.ded_flag;
    v[ICX_CT_MF_EN] = s.mf_en;
    v[ICX_CT_DED_EN_LSB +: 2] = s.ded_en;
    return v;
  endfunction : icx_ctrl_image

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [7:0] impl;
    logic [7:0] sh_old;
    logic [1:0] ded_old;
    logic [3:0] sh_set;
    logic mf_req;
    logic [2:0] pend;
    logic [2:0] ev;
    impl = icx_impl_mask();
    sh_set = 4'h0;
    mf_req = 1'b0;
    pend = 3'h0;
    s_next = s_reg;
    sh_old = s_reg.shared;
    ded_old = s_reg.ded_flag;
    ev = 3'h0;
    take = 1'b0;
    sel = ICX_SEL_NONE;
    wr_acc = psel && penable && s_reg.pready && pwrite;
    rd_acc = psel && penable && s_reg.pready && !pwrite;

    // APB: setup cycle prepares the one-cycle acknowledge
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.prdata = 32'h0000_0000;
    s_next.apb = ICX_APB_IDLE;
    if (psel && !penable) begin
      s_next.apb = ICX_APB_ACK;
      s_next.pready = 1'b1;
      case (paddr)
        ICX_OFF_SHARED: s_next.prdata = {24'h00_0000, s_reg.shared & impl};
        ICX_OFF_CTRL: s_next.prdata = {24'h00_0000, icx_ctrl_image(s_reg)};
        ICX_OFF_STAT: s_next.prdata = {29'h0000_0000, s_reg.stat};
        ICX_OFF_MASK: s_next.prdata = {29'h0000_0000, s_reg.mask};
        ICX_OFF_STACK: s_next.prdata = {{(32-SP_W){1'b0}}, s_reg.sp};
        default: s_next.pslverr = 1'b1;
      endcase
    end

    // Software writes at the access edge
    if (wr_acc) begin
      case (paddr)
        ICX_OFF_SHARED: s_next.shared = pwdata[7:0] & impl;
        ICX_OFF_CTRL: begin
          s_next.gie = pwdata[ICX_CT_GIE];
          s_next.mf_flag = pwdata[ICX_CT_MF_FLAG];
          s_next.ded_flag = pwdata[ICX_CT_DED_FLAG_LSB +: 2];
          s_next.mf_en = pwdata[ICX_CT_MF_EN];
          s_next.ded_en = pwdata[ICX_CT_DED_EN_LSB +: 2];
        end
        ICX_OFF_MASK: s_next.mask = pwdata[2:0];
        default: ;
      endcase
    end
    if (rd_acc && paddr == ICX_OFF_STAT) begin
      s_next.stat = 3'h0;
    end

    // Pending requests, gated by the source enables; global enable is checked at entry
    pend[0] = s_reg.ded_flag[0] && s_reg.ded_en[0];
    pend[1] = s_reg.ded_flag[1] && s_reg.ded_en[1];
    pend[2] = s_reg.mf_flag && s_reg.mf_en;

    // Core stack operations, then interrupt entry
    s_next.core.pc_load = 1'b0;
    if ((core_in.return_from_interrupt_instr || core_in.ret_pop) && s_reg.sp != '0) begin
      s_next.sp = s_reg.sp - 1'b1;
      s_next.core.pc_load = 1'b1;
      s_next.core.pc_target = s_reg.stack[s_reg.sp - 1'b1];
    end else if (core_in.call_push && s_reg.sp != SP_FULL) begin
      s_next.stack[s_reg.sp] = core_in.next_pc;
      s_next.sp = s_reg.sp + 1'b1;
    end else if (s_reg.gie && pend != 3'b000) begin
      if (s_reg.sp == SP_FULL) begin
        ev[ICX_ST_REFUSED] = 1'b1;
      end else begin
        take = 1'b1;
        // Fixed priority: dedicated 0, dedicated 1, shared vector
        if (pend[0]) begin
          sel = ICX_SEL_D0;
        end else if (pend[1]) begin
          sel = ICX_SEL_D1;
        end else begin
          sel = ICX_SEL_MF;
        end
      end
    end

    // Vector jump and entry side effects
    if (take) begin
      s_next.stack[s_reg.sp] = core_in.next_pc;
      s_next.sp = s_reg.sp + 1'b1;
      s_next.core.pc_load = 1'b1;
      s_next.gie = 1'b0;
      ev[ICX_ST_TAKEN] = 1'b1;
      case (sel)
        ICX_SEL_D0: begin
          s_next.core.pc_target = ICX_VEC_DED0;
          s_next.ded_flag[0] = 1'b0;
        end
        ICX_SEL_D1: begin
          s_next.core.pc_target = ICX_VEC_DED1;
          s_next.ded_flag[1] = 1'b0;
        end
        ICX_SEL_MF: begin
          s_next.core.pc_target = ICX_VEC_MF;
          s_next.mf_flag = 1'b0;
        end
        default: ;
      endcase
    end

    // Hardware sets win over any clear in the same cycle
    sh_set = {src_event.eeprom, src_event.serial_a,
              src_event.serial_module, src_event.low_volt};
    s_next.shared[ICX_SH_FLAG_LSB +: 4] = s_next.shared[ICX_SH_FLAG_LSB +: 4]
                                          | (sh_set & impl[ICX_SH_FLAG_LSB +: 4]);
    s_next.ded_flag = s_next.ded_flag | src_event.dedicated;

    // Grouped flag rises when an enabled shared source requests
    mf_req = |(s_next.shared[ICX_SH_FLAG_LSB +: 4] & s_next.shared[ICX_SH_EN_LSB +: 4]);
    s_next.mf_req_prev = mf_req;
    if (mf_req && !s_reg.mf_req_prev) begin
      s_next.mf_flag = 1'b1;
    end

    // Wake on any shared-source or dedicated flag newly set, grouped flag not included, enables ignored
    s_next.wake = |((s_next.shared[7:4] & ~sh_old[7:4]))
                  || |(s_next.ded_flag & ~ded_old);
    ev[ICX_ST_WAKE] = s_next.wake;

    // Sticky events, set wins over read clear
    s_next.stat = s_next.stat | ev;
    s_next.irq = |(s_next.stat & s_next.mask);
    s_next.core.stack_full = (s_next.sp == SP_FULL);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= icx_state_t'('0);
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign core_out = s_reg.core;
  assign wake_pulse = s_reg.wake;
  assign irq = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_take_needs_enable: assert property (
    s_reg.core.pc_load && s_reg.sp == $past(s_reg.sp) + 1'b1
      |-> $past(s_reg.gie)
      && (s_reg.core.pc_target != ICX_VEC_DED0 || $past(s_reg.ded_en[0]))
      && (s_reg.core.pc_target != ICX_VEC_DED1 || $past(s_reg.ded_en[1]))
      && (s_reg.core.pc_target != ICX_VEC_MF || $past(s_reg.mf_en)))
    else $error("interrupt taken while disabled");

  a_take_clears_gie: assert property (
    take && !wr_acc |=> !s_reg.gie && s_reg.core.pc_load)
    else $error("global enable not cleared on entry");

  a_take_pushes_pc: assert property (
    take |=> s_reg.sp == $past(s_reg.sp) + 1'b1
      && s_reg.stack[$past(s_reg.sp)] == $past(core_in.next_pc))
    else $error("return address not pushed");

  a_full_refuses: assert property (
    s_reg.sp == SP_FULL && !core_in.ret_pop && !core_in.return_from_interrupt_instr
      |=> !s_reg.core.pc_load && s_reg.sp == SP_FULL)
    else $error("interrupt taken with full stack");

  a_priority_order: assert property (
    take && s_reg.ded_flag[0] && s_reg.ded_en[0] |=> s_reg.core.pc_target == ICX_VEC_DED0)
    else $error("priority order broken");

  a_flag_held: assert property (
    src_event.low_volt |=> s_reg.shared[ICX_SH_FLAG_LSB])
    else $error("request flag lost");

  a_mf_keeps_sources: assert property (
    take && sel == ICX_SEL_MF && !wr_acc
      |=> (s_reg.shared & $past(s_reg.shared)) == $past(s_reg.shared))
    else $error("source flag cleared by service");

  a_wake_on_set: assert property (
    src_event.eeprom && !s_reg.shared[7] |=> s_reg.wake)
    else $error("no wake on new flag");

  a_return_from_interrupt_instr_pops: assert property (
    core_in.return_from_interrupt_instr && s_reg.sp != '0
      |=> s_reg.core.pc_load && s_reg.sp == $past(s_reg.sp) - 1'b1)
    else $error("return did not pop");

  a_unimpl_zero: assert property (
    !HAS_SERIAL_MODULE |-> !s_reg.shared[ICX_SH_SM_FLAG] && !s_reg.shared[ICX_SH_SM_EN])
    else $error("unimplemented bit set");

endmodule : icx_ctrl

/* verilog/icx_pkg.sv */
// Constants and types of the interrupt controller.
// Assumes one 25 MHz clock shared with the processor core and APB.
package icx_pkg;

  // Register byte offsets
  localparam logic [7:0] ICX_OFF_SHARED = 8'h00;
  localparam logic [7:0] ICX_OFF_CTRL = 8'h04;
  localparam logic [7:0] ICX_OFF_STAT = 8'h08;
  localparam logic [7:0] ICX_OFF_MASK = 8'h0C;
  localparam logic [7:0] ICX_OFF_STACK = 8'h10;

  // Shared-vector register fields
  localparam int ICX_SH_FLAG_LSB = 4;
  localparam int ICX_SH_EN_LSB = 0;
  localparam int ICX_SH_SM_FLAG = 5;
  localparam int ICX_SH_SM_EN = 1;

  // Control register fields
  localparam int ICX_CT_GIE = 7;
  localparam int ICX_CT_MF_FLAG = 6;
  localparam int ICX_CT_DED_FLAG_LSB = 4;
  localparam int ICX_CT_MF_EN = 3;
  localparam int ICX_CT_DED_EN_LSB = 0;

  // Event status bits
  localparam int ICX_ST_TAKEN = 0;
  localparam int ICX_ST_WAKE = 1;
  localparam int ICX_ST_REFUSED = 2;

  // Reset values
  localparam logic [7:0] ICX_RST_SHARED = 8'h00;
  localparam logic [7:0] ICX_RST_CTRL = 8'h00;
  localparam logic [2:0] ICX_RST_MASK = 3'h0;

  // Program counter width and vectors
  localparam int ICX_PC_W = 12;
  localparam logic [ICX_PC_W-1:0] ICX_VEC_DED0 = 12'h004;
  localparam logic [ICX_PC_W-1:0] ICX_VEC_DED1 = 12'h008;
  localparam logic [ICX_PC_W-1:0] ICX_VEC_MF = 12'h00C;
  localparam int ICX_STACK_DEPTH = 8;

  typedef enum logic [0:0] {
    ICX_APB_IDLE = 1'b0,
    ICX_APB_ACK = 1'b1
  } icx_apb_t;

  typedef enum logic [1:0] {
    ICX_SEL_NONE = 2'b00,
    ICX_SEL_D0 = 2'b01,
    ICX_SEL_D1 = 2'b10,
    ICX_SEL_MF = 2'b11
  } icx_sel_t;

  // One-cycle event pulses from the peripherals
  typedef struct packed {
    logic [1:0] dedicated;
    logic eeprom;
    logic serial_a;
    logic serial_module;
    logic low_volt;
  } icx_src_t;

  // Requests from the processor core
  typedef struct packed {
    logic [ICX_PC_W-1:0] next_pc;
    logic call_push;
    logic ret_pop;
    logic return_from_interrupt_instr;
  } icx_core_in_t;

  // Answers to the processor core
  typedef struct packed {
    logic pc_load;
    logic [ICX_PC_W-1:0] pc_target;
    logic stack_full;
  } icx_core_out_t;

endpackage : icx_pkg

/* dv/icx_core_model.sv */
// Core model: drives call, pop, interrupt return and next PC.
// Assumes one request per cycle, driven just after a rising edge.
module icx_core_model
  import icx_pkg::*;
(
  input wire logic pclk,
  input wire icx_core_out_t core_out,
  output icx_core_in_t core_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ICX_PC_W-1:0] loads[$];
  initial core_in = '0;
  // Log every vector or return target
  always @(posedge pclk) begin
    if (core_out.pc_load === 1'b1) loads.push_back(core_out.pc_target);
  end
  // One request pulse; next PC stays until the next request
  task automatic req(input logic [2:0] m, input logic [ICX_PC_W-1:0] pc);
    @(posedge pclk);
    core_in.next_pc <= pc;
    core_in.call_push <= m[2];
    core_in.ret_pop <= m[1];
    core_in.return_from_interrupt_instr <= m[0];
    @(posedge pclk);
    core_in.call_push <= 1'b0;
    core_in.ret_pop <= 1'b0;
    core_in.return_from_interrupt_instr <= 1'b0;
  endtask : req
endmodule : icx_core_model

/* dv/icx_ctrl_test.sv */
// Testbench of the interrupt controller: APB tasks, events, core model.
// Assumes one APB access phase per transfer and PC loads a cycle later.
module icx_ctrl_test
  import icx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  icx_src_t src_event;
  icx_core_in_t core_in;
  icx_core_out_t core_out;
  logic wake_pulse;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch;
  int samples_checked;
  int n_wake = 0;
  int wake_base;

  icx_ctrl icx_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event), .core_in(core_in),
    .core_out(core_out), .wake_pulse(wake_pulse), .irq(irq));
  icx_core_model icx_core_model_i (.pclk(pclk), .core_out(core_out), .core_in(core_in));

  // Count wake pulses seen at each rising edge
  always @(posedge pclk) begin
    if (wake_pulse === 1'b1) n_wake <= n_wake + 1;
  end

  // Clock at 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // APB transfer; waits for pready under a bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task automatic ev(input logic [5:0] v);
    @(posedge pclk);
    src_event <= icx_src_t'(v);
    @(posedge pclk);
    src_event <= '0;
  endtask : ev

  task automatic wait_load(input logic [11:0] exp);
    int i;
    for (i = 0; i < 30 && icx_core_model_i.loads.size() == 0; i++) @(posedge pclk);
    if (icx_core_model_i.loads.size() == 0) begin
      n_mismatch++;
      results();
    end else begin
      chk(32'(icx_core_model_i.loads.pop_front()), 32'(exp));
    end
  endtask : wait_load

  task automatic no_load();
    repeat (6) @(posedge pclk);
    chk(32'(icx_core_model_i.loads.size()), 32'h0);
  endtask : no_load

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_event = '0;
    presetn = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ICX_OFF_SHARED, 32'h00);
    rd(ICX_OFF_CTRL, 32'h00);
    rd(ICX_OFF_MASK, 32'h00);
    rd(8'h20, 32'h00);
    chk(32'(rerr), 32'h1);
    xfer(1'b1, ICX_OFF_SHARED, 32'hFF);
    rd(ICX_OFF_SHARED, 32'hFF);
    rd(ICX_OFF_CTRL, 32'h40);
    xfer(1'b1, ICX_OFF_SHARED, 32'h00);
    xfer(1'b1, ICX_OFF_CTRL, 32'h00);
    xfer(1'b0, ICX_OFF_STAT, 32'h0);
    wake_base = n_wake;
    ev(6'h10);
    rd(ICX_OFF_CTRL, 32'h10);
    chk(32'(n_wake - wake_base), 32'h1);
    no_load();
    chk(32'(irq), 32'h0);
    xfer(1'b1, ICX_OFF_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rd(ICX_OFF_STAT, 32'h02);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    // Preset flag keeps the source from waking
    xfer(1'b1, ICX_OFF_CTRL, 32'h10);
    xfer(1'b0, ICX_OFF_STAT, 32'h0);
    wake_base = n_wake;
    ev(6'h10);
    rd(ICX_OFF_STAT, 32'h00);
    chk(32'(n_wake - wake_base), 32'h0);
    xfer(1'b1, ICX_OFF_CTRL, 32'h11);
    no_load();
    rd(ICX_OFF_CTRL, 32'h11);
    icx_core_model_i.req(3'b000, 12'h123);
    xfer(1'b1, ICX_OFF_CTRL, 32'h91);
    wait_load(ICX_VEC_DED0);
    rd(ICX_OFF_CTRL, 32'h01);
    rd(ICX_OFF_STACK, 32'h01);
    ev(6'h20);
    rd(ICX_OFF_CTRL, 32'h21);
    icx_core_model_i.req(3'b001, 12'h123);
    wait_load(12'h123);
    rd(ICX_OFF_STACK, 32'h00);
    chk(32'(core_out.stack_full), 32'h0);
    // Two pending dedicated requests, nesting re-enabled by software
    icx_core_model_i.req(3'b000, 12'h200);
    xfer(1'b1, ICX_OFF_CTRL, 32'hB3);
    wait_load(ICX_VEC_DED0);
    rd(ICX_OFF_CTRL, 32'h23);
    icx_core_model_i.req(3'b000, 12'h210);
    xfer(1'b1, ICX_OFF_CTRL, 32'hA3);
    wait_load(ICX_VEC_DED1);
    icx_core_model_i.req(3'b001, 12'h210);
    wait_load(12'h210);
    icx_core_model_i.req(3'b001, 12'h200);
    wait_load(12'h200);
    // Grouped source through the shared vector
    xfer(1'b1, ICX_OFF_CTRL, 32'h00);
    xfer(1'b1, ICX_OFF_SHARED, 32'h11);
    xfer(1'b1, ICX_OFF_CTRL, 32'hC8);
    wait_load(ICX_VEC_MF);
    rd(ICX_OFF_SHARED, 32'h11);
    rd(ICX_OFF_CTRL, 32'h08);
    icx_core_model_i.req(3'b001, 12'h200);
    wait_load(12'h200);
    // Full stack refuses entry until a pop
    for (int i = 0; i < 8; i++) icx_core_model_i.req(3'b100, 12'h300 + 12'(i));
    rd(ICX_OFF_STACK, 32'h08);
    chk(32'(core_out.stack_full), 32'h1);
    xfer(1'b0, ICX_OFF_STAT, 32'h0);
    xfer(1'b1, ICX_OFF_CTRL, 32'h81);
    ev(6'h10);
    no_load();
    rd(ICX_OFF_STAT, 32'h06);
    icx_core_model_i.req(3'b010, 12'h307);
    wait_load(12'h307);
    wait_load(ICX_VEC_DED0);
    results();
  end
endmodule : icx_ctrl_test
